/* core/dec_defines.svh */
`ifndef DEC_DEFINES_SVH
`define DEC_DEFINES_SVH
// Counter width in bits.
`define DEC_CW            16
// Clock source field width and the stopped code.
`define DEC_CLOCK_SOURCE_SELECT_W        2
`define DEC_CLOCK_SOURCE_SELECT_STOP     2'h0
// Edge select codes (B:A).
`define DEC_EDGE_RISE     2'h1
`define DEC_EDGE_FALL     2'h2
// Channel indices whose even input may use the filter.
`define DEC_FILT_IDX0     2'h0
`define DEC_FILT_IDX1     2'h2
// Counter reset value and filter count limit.
`define DEC_CNT_RST       16'h0000
`define DEC_FILT_LEN      4'h4
`endif

/* core/dec_pkg.sv */
package dec_pkg;
  // Dual capture progress within one edge pair.
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FIRST = 2'b01,
    ST_DONE  = 2'b10
  } cap_state_e;
endpackage

/* core/dec_edge_detect.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dec_defines.svh"
// Synchronises the pin, optionally filters it, and flags both edges.
module dec_edge_detect (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic pin_in,
  input  wire logic filter_on,
  output logic      rise_p,
  output logic      fall_p
);
  typedef struct packed {
    logic       s1;
    logic       s2;
    logic [3:0] cnt;
    logic       lvl;
    logic       rise;
    logic       fall;
  } ed_s;
  ed_s st_r;   // Registered state.
  ed_s st_nxt; // Next state.

  // The first stage feeds only the second; filter and edge logic use s2.
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.rise = 1'b0;
    st_nxt.fall = 1'b0;
    if (st_r.s2 == st_r.lvl) begin
      st_nxt.cnt = 4'h0;
    end else if (!filter_on || st_r.cnt == `DEC_FILT_LEN) begin
      // A new level is accepted once stable long enough.
      st_nxt.lvl = st_r.s2;
      st_nxt.cnt = 4'h0;
      st_nxt.rise = st_r.s2;
      st_nxt.fall = !st_r.s2;
    end else begin
      st_nxt.cnt = st_r.cnt + 4'h1;
    end
  end

  // State register.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rise_p = st_r.rise;
  assign fall_p = st_r.fall;
endmodule // dec_edge_detect
`default_nettype wire

/* core/dec_counter.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dec_defines.svh"
// Up counter that wraps from the limit back to the initial value.
module dec_counter (
  input  wire logic                   ref_clk,
  input  wire logic                   reset_n,
  input  wire logic                   run,
  input  wire logic                   load,
  input  wire logic [`DEC_CW-1:0]     load_val,
  input  wire logic                   sync_load,
  input  wire logic [`DEC_CW-1:0]     init_val,
  input  wire logic [`DEC_CW-1:0]     wrap_val,
  output logic      [`DEC_CW-1:0]     count,
  output logic                        wrapped_p
);
  typedef struct packed {
    logic [`DEC_CW-1:0] cnt;
    logic               wrap;
  } ctr_s;
  ctr_s st_r;   // Registered state.
  ctr_s st_nxt; // Next state.

  // Step from v: wrap to the initial value at the limit.
  function automatic logic [`DEC_CW-1:0] step(input logic [`DEC_CW-1:0] v,
      input logic [`DEC_CW-1:0] lim, input logic [`DEC_CW-1:0] ini);
    step = (v == lim) ? ini : v + 16'h0001;
  endfunction

  // Load has priority; a loaded value steps once so it reads as next value.
  always_comb begin
    st_nxt = st_r;
    st_nxt.wrap = 1'b0;
    if (load) begin
      st_nxt.cnt = step(load_val, wrap_val, init_val);
    end else if (sync_load) begin
      st_nxt.cnt = init_val;
    end else if (run) begin
      st_nxt.cnt = step(st_r.cnt, wrap_val, init_val);
      st_nxt.wrap = (st_r.cnt == wrap_val);
    end
  end

  // State register.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '{cnt: `DEC_CNT_RST, wrap: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign count = st_r.cnt;
  assign wrapped_p = st_r.wrap;
endmodule // dec_counter
`default_nettype wire

/* core/dual_edge_capture_unit.sv */
// Function
// - Auto reload emits init trigger when enabled
// - Counter write emits init trigger when enabled
// - Synchronization reload emits init trigger when enabled
// - Starting clock at initial value emits trigger
// - Test mode freezes counter; writes load it
// - Test write fills values, sets flags
// - Values read written data; counter reads next
// - Dual capture needs both enable bits
// - Even filter only on pair indices 0, 2
// - Mode select A: one-shot or continuous
// - Same edges period, different edges width
// - Rise/fall positive width, fall/rise negative
// - Only even input pin is watched
// - Even edge sets even flag, interrupt
// - Odd edge sets odd flag after even
// - Value registers capture counter at edges
// - Captures need arm; one-shot clears arm
// - Continuous keeps last pair after disarm
// - Each new odd flag means fresh pair
// - Odd capture buffered until even read
`timescale 1ns/10ps
`default_nettype none
`include "dec_defines.svh"
module dual_edge_capture_unit (
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  input  wire logic                  even_pin,
  input  wire logic                  odd_pin,
  input  wire logic [1:0]            pair_index,
  input  wire logic                  filter_enable,
  input  wire logic                  extended_timer_enable,
  input  wire logic                  dual_capture_enable,
  input  wire logic                  mode_select_a,
  input  wire logic [1:0]            even_edge_select,
  input  wire logic [1:0]            odd_edge_select,
  input  wire logic                  even_channel_irq_enable,
  input  wire logic                  odd_channel_irq_enable,
  input  wire logic                  init_trigger_enable,
  input  wire logic                  capture_test_enable,
  input  wire logic [`DEC_CLOCK_SOURCE_SELECT_W-1:0] clock_source_select,
  input  wire logic [`DEC_CW-1:0]    counter_initial_value,
  input  wire logic [`DEC_CW-1:0]    wrap_limit,
  input  wire logic                  counter_write,
  input  wire logic [`DEC_CW-1:0]    counter_wdata,
  input  wire logic                  counter_sync,
  input  wire logic                  arm_set,
  input  wire logic                  arm_clear,
  input  wire logic                  even_flag_clear,
  input  wire logic                  odd_flag_clear,
  input  wire logic                  even_value_read,
  output logic [`DEC_CW-1:0]         counter_register,
  output logic [`DEC_CW-1:0]         even_channel_value,
  output logic [`DEC_CW-1:0]         odd_channel_value,
  output logic                       even_channel_flag,
  output logic                       odd_channel_flag,
  output logic                       even_channel_irq,
  output logic                       odd_channel_irq,
  output logic                       dual_capture_arm,
  output logic                       period_mode,
  output logic                       init_trigger
);
  typedef struct packed {
    logic [`DEC_CW-1:0]      ev_val;
    logic [`DEC_CW-1:0]      od_val;
    logic [`DEC_CW-1:0]      od_buf;
    logic                    od_pend;
    logic                    ev_flag;
    logic                    od_flag;
    logic                    ev_irq;
    logic                    od_irq;
    logic                    arm;
    logic                    period;
    logic                    trig;
    logic [`DEC_CLOCK_SOURCE_SELECT_W-1:0]  clock_source_select_d;
    dec_pkg::cap_state_e     cst;
  } cap_s;
  cap_s st_r;   // Registered state.
  cap_s st_nxt; // Next state.

  logic [`DEC_CW-1:0] count;      // Live counter value.
  logic               wrapped_p;  // Counter reloaded by its own wrap.
  logic               rise_p;     // Accepted rising edge of even pin.
  logic               fall_p;     // Accepted falling edge of even pin.
  logic               dual_mode;  // Dual edge capture selected.
  logic               use_filter; // Filter allowed on this pair.
  logic               run;        // Counter advances this cycle.
  logic               clk_start;  // Clock source goes from stopped to running.
  logic               ev_hit;     // Even channel edge seen.
  logic               od_hit;     // Odd channel edge seen.

  // Selected edge matches; only 0:1 and 1:0 are meaningful codes.
  function automatic logic edge_hit(input logic [1:0] sel,
      input logic r, input logic f);
    edge_hit = (sel == `DEC_EDGE_RISE && r) || (sel == `DEC_EDGE_FALL && f);
  endfunction

  assign dual_mode = extended_timer_enable && dual_capture_enable;
  // The filter costs latency, so it exists only on pairs 0 and 2.
  assign use_filter = filter_enable && dual_mode &&
                      (pair_index == `DEC_FILT_IDX0 ||
                       pair_index == `DEC_FILT_IDX1);
  // Test mode freezes the counter; a stopped clock source also halts it.
  assign run = !capture_test_enable &&
               (clock_source_select != `DEC_CLOCK_SOURCE_SELECT_STOP);
  assign clk_start = (st_r.clock_source_select_d == `DEC_CLOCK_SOURCE_SELECT_STOP) &&
                     (clock_source_select != `DEC_CLOCK_SOURCE_SELECT_STOP);

  // The odd pin is left unconnected to capture logic entirely.
  dec_edge_detect u_edge (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .pin_in    (even_pin),
    .filter_on (use_filter),
    .rise_p    (rise_p),
    .fall_p    (fall_p)
  );

  dec_counter u_ctr (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .run       (run),
    .load      (counter_write && capture_test_enable),
    .load_val  (counter_wdata),
    .sync_load ((counter_write && !capture_test_enable) || counter_sync),
    .init_val  (counter_initial_value),
    .wrap_val  (wrap_limit),
    .count     (count),
    .wrapped_p (wrapped_p)
  );

  // Both channels judge edges of the even input only.
  assign ev_hit = dual_mode && st_r.arm &&
                  edge_hit(even_edge_select, rise_p, fall_p);
  assign od_hit = dual_mode && st_r.arm &&
                  edge_hit(odd_edge_select, rise_p, fall_p);

  // Capture, flag, arm and trigger logic.
  always_comb begin
    st_nxt = st_r;
    st_nxt.clock_source_select_d = clock_source_select;
    st_nxt.period = (even_edge_select == odd_edge_select);
    // One clock pulse per reload event, any source.
    st_nxt.trig = init_trigger_enable &&
                  (wrapped_p ||
                   counter_write ||
                   counter_sync ||
                   (clk_start && count == counter_initial_value));
    // Software clears first, so a same-cycle arm_set wins below.
    if (arm_clear) begin
      st_nxt.arm = 1'b0;
    end
    if (arm_set) begin
      st_nxt.arm = 1'b1;
    end
    // Clearing the even flag restarts pairing from the idle step.
    if (even_flag_clear) begin
      st_nxt.ev_flag = 1'b0;
      st_nxt.cst = dec_pkg::ST_IDLE;
    end
    // Continuous mode may clear the odd flag alone between pairs.
    if (odd_flag_clear) begin
      st_nxt.od_flag = 1'b0;
    end
    // Odd capture waits in a buffer until the even value is read.
    if (even_value_read && st_r.od_pend) begin
      st_nxt.od_val = st_r.od_buf;
      st_nxt.od_pend = 1'b0;
    end
    if (capture_test_enable && counter_write) begin
      // Test write lands in every value register and sets every flag.
      st_nxt.ev_val = counter_wdata;
      st_nxt.od_val = counter_wdata;
      st_nxt.od_pend = 1'b0;
      st_nxt.ev_flag = 1'b1;
      st_nxt.od_flag = 1'b1;
    end else begin
      // Odd edge counts only once the even flag stands.
      if (od_hit && st_r.ev_flag) begin
        st_nxt.od_buf = count;
        st_nxt.od_pend = 1'b1;
        st_nxt.od_flag = 1'b1;
        st_nxt.cst = dec_pkg::ST_DONE;
        if (!mode_select_a) begin
          st_nxt.arm = 1'b0;
        end
      end
      // In a period pair the same edge ends one pair and opens the next.
      if (ev_hit && (!od_hit || !st_r.ev_flag || st_r.period)) begin
        st_nxt.ev_val = count;
        st_nxt.ev_flag = 1'b1;
        if (st_nxt.cst != dec_pkg::ST_DONE) begin
          st_nxt.cst = dec_pkg::ST_FIRST;
        end
      end
    end
    // Disarm never touches the values, so the last pair stays readable.
    st_nxt.ev_irq = st_nxt.ev_flag && even_channel_irq_enable;
    st_nxt.od_irq = st_nxt.od_flag && odd_channel_irq_enable;
  end

  // State register.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '{ev_val: `DEC_CNT_RST, od_val: `DEC_CNT_RST,
                od_buf: `DEC_CNT_RST, clock_source_select_d: `DEC_CLOCK_SOURCE_SELECT_STOP,
                cst: dec_pkg::ST_IDLE, default: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign counter_register   = count;
  assign even_channel_value = st_r.ev_val;
  assign odd_channel_value  = st_r.od_val;
  assign even_channel_flag  = st_r.ev_flag;
  assign odd_channel_flag   = st_r.od_flag;
  assign even_channel_irq   = st_r.ev_irq;
  assign odd_channel_irq    = st_r.od_irq;
  assign dual_capture_arm   = st_r.arm;
  assign period_mode        = st_r.period;
  assign init_trigger       = st_r.trig;

  // Checks. Every one runs on ref_clk and is off while reset is held,
  // so the reset values of the flops never trip them.

  // A capture test write: strobe and test mode in one cycle.
  sequence s_test_wr;
    capture_test_enable && counter_write;
  endsequence

  // First step of a pair: the even edge is accepted and latched.
  sequence s_even_cap;
    ev_hit && !(capture_test_enable && counter_write) &&
      (!od_hit || !st_r.ev_flag || st_r.period);
  endsequence

  // Second step: the odd edge lands while the even flag stands.
  sequence s_odd_cap;
    od_hit && st_r.ev_flag && !(capture_test_enable && counter_write);
  endsequence

  // Trigger sources, each one cycle ahead of the pulse.
  AST_TRIG_WRAP: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    init_trigger_enable && wrapped_p |=> init_trigger)
    else $error("no trigger after wrap");
  AST_TRIG_WRITE: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    init_trigger_enable && counter_write |=> init_trigger)
    else $error("no trigger after counter write");
  AST_TRIG_SYNC: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    init_trigger_enable && counter_sync |=> init_trigger)
    else $error("no trigger after sync");
  AST_TRIG_START: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    init_trigger_enable && clk_start && count == counter_initial_value
      |=> init_trigger)
    else $error("no trigger at clock start");
  AST_TRIG_OFF: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !init_trigger_enable |=> !init_trigger)
    else $error("trigger while disabled");
  // A pulse with no reload behind it would fire other blocks twice.
  AST_TRIG_CAUSE: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    init_trigger |-> $past(init_trigger_enable && (wrapped_p ||
      counter_write || counter_sync ||
      (clk_start && count == counter_initial_value))))
    else $error("trigger without a reload");

  // Capture test mode.
  AST_FREEZE: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    capture_test_enable && !counter_write && !counter_sync
      |=> $stable(counter_register))
    else $error("counter moved in test mode");
  AST_TEST_FILL: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    s_test_wr |=> even_channel_value == $past(counter_wdata) &&
      odd_channel_value == $past(counter_wdata) &&
      even_channel_flag && odd_channel_flag)
    else $error("test write not copied");
  AST_TEST_NEXT: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    s_test_wr |=> counter_register == (($past(counter_wdata) ==
      $past(wrap_limit)) ? $past(counter_initial_value) :
      $past(counter_wdata) + 16'h0001))
    else $error("counter not at next value after test write");

  // Dual edge capture.
  AST_NO_DUAL: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !dual_mode && !capture_test_enable |=> $stable(even_channel_value))
    else $error("capture outside dual mode");
  AST_EVEN_SET: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    s_even_cap |=> even_channel_flag &&
      even_channel_value == $past(count))
    else $error("even edge not captured");
  AST_ODD_BUF: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    s_odd_cap |=> odd_channel_flag && st_r.od_pend &&
      st_r.od_buf == $past(count))
    else $error("odd edge not buffered");
  AST_ODD_NEEDS_EVEN: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(odd_channel_flag) && !$past(capture_test_enable)
      |-> $past(even_channel_flag))
    else $error("odd flag without even flag");
  AST_COHERENT: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    even_value_read && st_r.od_pend && !(capture_test_enable &&
      counter_write) |=> odd_channel_value == $past(st_r.od_buf))
    else $error("odd buffer not moved on even read");
  // Without the hold, a read pair could mix two different pulses.
  AST_ODD_HOLD: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !even_value_read && !(capture_test_enable && counter_write)
      |=> $stable(odd_channel_value))
    else $error("odd value moved without even read");
  AST_ARM_NEEDED: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    !dual_capture_arm && !capture_test_enable
      |=> $stable(even_channel_value))
    else $error("capture while disarmed");
  AST_ONESHOT: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    od_hit && st_r.ev_flag && !mode_select_a && !arm_set
      && !capture_test_enable |=> !dual_capture_arm)
    else $error("one-shot arm not cleared");
  AST_CONTINUOUS: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    s_odd_cap ##0 (mode_select_a && !arm_clear) |=> dual_capture_arm)
    else $error("continuous mode dropped arm");
  AST_PERIOD: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    even_edge_select == odd_edge_select |=> period_mode)
    else $error("equal edges not period");
  AST_WIDTH: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    even_edge_select != odd_edge_select |=> !period_mode)
    else $error("different edges not width");
  AST_IRQ_EVEN: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    even_channel_irq |-> even_channel_flag)
    else $error("even request without flag");
  AST_IRQ_ODD: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    odd_channel_irq |-> odd_channel_flag)
    else $error("odd request without flag");
endmodule // dual_edge_capture_unit
`default_nettype wire

/* bench/pulse_source.sv */
`timescale 1ns/10ps
`default_nettype none
// Far-side signal source: one pulse per request on the even pin.
module pulse_source (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic       go,
  input  wire logic       pol,
  input  wire logic [7:0] width,
  output logic            even_pin,
  output logic            odd_pin
);
  logic [7:0] cnt_r; // Cycles of active level still to send.

  // The odd pin toggles every cycle so that any use of it shows up.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r   <= 8'h00;
      odd_pin <= 1'h0;
    end else begin
      odd_pin <= ~odd_pin;
      if (go) begin
        cnt_r <= width;
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end

  // A low polarity idles high, so the pulse is the negative kind.
  assign even_pin = (cnt_r != 8'h00) ? pol : ~pol;
endmodule // pulse_source
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dec_defines.svh"
// Bench: strobe and pin tasks, then compare against expected values.
module tb_top;
  logic ref_clk, reset_n, even_pin, odd_pin, go, pol;
  logic [1:0] pair_index, even_edge_select, odd_edge_select;
  logic [`DEC_CLOCK_SOURCE_SELECT_W-1:0] clock_source_select;
  logic filter_enable, extended_timer_enable, dual_capture_enable;
  logic mode_select_a, even_channel_irq_enable, odd_channel_irq_enable;
  logic init_trigger_enable, capture_test_enable;
  logic [`DEC_CW-1:0] counter_initial_value, wrap_limit, counter_wdata;
  logic [`DEC_CW-1:0] counter_register, even_channel_value;
  logic [`DEC_CW-1:0] odd_channel_value, ev0, od0;
  logic even_channel_flag, odd_channel_flag, even_channel_irq;
  logic odd_channel_irq, dual_capture_arm, period_mode, init_trigger;
  logic [7:0] width;
  logic [6:0] stb; // One-cycle strobes, indexed by the constants below.
  wire logic counter_write, counter_sync, arm_set, arm_clear;
  wire logic even_flag_clear, odd_flag_clear, even_value_read;
  int n_errors, compares;
  localparam int WR = 0, SY = 1, AS = 2, AC = 3, EC = 4, OC = 5, RD = 6;
  assign {even_value_read, odd_flag_clear, even_flag_clear, arm_clear,
          arm_set, counter_sync, counter_write} = stb;

  dual_edge_capture_unit u_dual_edge_capture_unit (
    .ref_clk, .reset_n, .even_pin, .odd_pin, .pair_index, .filter_enable,
    .extended_timer_enable, .dual_capture_enable, .mode_select_a,
    .even_edge_select, .odd_edge_select, .even_channel_irq_enable,
    .odd_channel_irq_enable, .init_trigger_enable, .capture_test_enable,
    .clock_source_select, .counter_initial_value, .wrap_limit,
    .counter_write, .counter_wdata, .counter_sync, .arm_set, .arm_clear,
    .even_flag_clear, .odd_flag_clear, .even_value_read, .counter_register,
    .even_channel_value, .odd_channel_value, .even_channel_flag,
    .odd_channel_flag, .even_channel_irq, .odd_channel_irq,
    .dual_capture_arm, .period_mode, .init_trigger
  );
  pulse_source u_pulse_source (
    .ref_clk, .reset_n, .go, .pol, .width, .even_pin, .odd_pin
  );

  // Free-running 250 MHz clock.
  initial begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Compares one value, counting every comparison and mismatch.
  task check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One-cycle strobe, raised and dropped on falling edges.
  task strobe(input int k);
    @(negedge ref_clk);
    stb[k] = 1'h1;
    @(negedge ref_clk);
    stb[k] = 1'h0;
  endtask

  // Sends one pulse and waits out its length plus sync and filter delay.
  task pulse(input logic [7:0] w);
    @(negedge ref_clk);
    width = w;
    go = 1'h1;
    @(negedge ref_clk);
    go = 1'h0;
    repeat (int'(w) + 16) @(negedge ref_clk);
  endtask

  // Reads the even value, then checks the odd-minus-even distance.
  task meas(input logic [15:0] w);
    strobe(RD);
    @(negedge ref_clk);
    check(odd_channel_value - even_channel_value, w);
  endtask

  // Counts trigger cycles over n cycles, the current one included, so a
  // pulse launched by the last strobe edge is not missed.
  task trig(input int n, input int exp);
    int c;
    c = 0;
    repeat (n) begin
      if (init_trigger === 1'h1) c++;
      @(negedge ref_clk);
    end
    check(16'(c), 16'(exp));
  endtask

  // Prints the counts and the verdict, then ends the run.
  task test_done;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog: the tests need well under two thousand cycles.
  initial begin
    #80000;
    n_errors++;
    test_done;
  end

  // Main sequence.
  initial begin
    {reset_n, go, pol, filter_enable, extended_timer_enable} = 5'h04;
    {dual_capture_enable, mode_select_a, init_trigger_enable} = 3'h0;
    {capture_test_enable, even_channel_irq_enable} = 2'h0;
    odd_channel_irq_enable = 1'h0;
    {pair_index, clock_source_select, stb, width} = 19'h0;
    even_edge_select = `DEC_EDGE_RISE;
    odd_edge_select = `DEC_EDGE_FALL;
    counter_initial_value = 16'h0000;
    wrap_limit = 16'hFFFF;
    counter_wdata = 16'h0000;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'h1;
    @(negedge ref_clk);
    check(odd_channel_value, 16'h0000);
    check(16'(dual_capture_arm), 16'h0000);
    clock_source_select = 2'h1;
    extended_timer_enable = 1'h1;
    {even_channel_irq_enable, odd_channel_irq_enable} = 2'h3;
    strobe(AS);
    pulse(8'h08);
    check(16'(even_channel_flag), 16'h0000);
    dual_capture_enable = 1'h1;
    // Filter applies only on pairs 0 and 2; two cycles is a glitch.
    filter_enable = 1'h1;
    strobe(EC);
    strobe(OC);
    strobe(AS);
    pulse(8'h02);
    check(16'(even_channel_flag), 16'h0000);
    pair_index = 2'h1;
    pulse(8'h02);
    check(16'(even_channel_flag), 16'h0001);
    filter_enable = 1'h0;
    strobe(EC);
    strobe(OC);
    strobe(AS);
    pulse(8'h0A);
    check(16'(even_channel_flag), 16'h0001);
    check(16'(odd_channel_flag), 16'h0001);
    check(16'(dual_capture_arm), 16'h0000);
    check(16'(even_channel_irq), 16'h0001);
    check(16'(odd_channel_irq), 16'h0001);
    check(odd_channel_value, 16'h0000);
    meas(16'h000A);
    // Negative pulse: polarity flips while disarmed, so it is ignored.
    pol = 1'h0;
    even_edge_select = `DEC_EDGE_FALL;
    odd_edge_select = `DEC_EDGE_RISE;
    strobe(EC);
    strobe(OC);
    strobe(AS);
    pulse(8'h07);
    meas(16'h0007);
    pol = 1'h1;
    even_edge_select = `DEC_EDGE_RISE;
    odd_edge_select = `DEC_EDGE_FALL;
    mode_select_a = 1'h1;
    strobe(EC);
    strobe(OC);
    strobe(AS);
    pulse(8'h09);
    check(16'(dual_capture_arm), 16'h0001);
    meas(16'h0009);
    strobe(OC);
    check(16'(odd_channel_flag), 16'h0000);
    pulse(8'h05);
    check(16'(odd_channel_flag), 16'h0001);
    meas(16'h0005);
    strobe(AC);
    ev0 = even_channel_value;
    od0 = odd_channel_value;
    pulse(8'h03);
    check(even_channel_value, ev0);
    check(odd_channel_value, od0);
    odd_edge_select = `DEC_EDGE_RISE;
    repeat (2) @(negedge ref_clk);
    check(16'(period_mode), 16'h0001);
    odd_edge_select = `DEC_EDGE_FALL;
    repeat (2) @(negedge ref_clk);
    check(16'(period_mode), 16'h0000);
    // Capture test with plain input capture and up counting.
    {mode_select_a, dual_capture_enable} = 2'h0;
    capture_test_enable = 1'h1;
    counter_wdata = 16'h1234;
    strobe(WR);
    check(even_channel_value, 16'h1234);
    check(odd_channel_value, 16'h1234);
    check(16'({even_channel_flag, odd_channel_flag}), 16'h0003);
    check(counter_register, 16'h1235);
    repeat (5) @(negedge ref_clk);
    check(counter_register, 16'h1235);
    capture_test_enable = 1'h0;
    init_trigger_enable = 1'h1;
    strobe(WR);
    trig(4, 1);
    strobe(SY);
    trig(4, 1);
    clock_source_select = `DEC_CLOCK_SOURCE_SELECT_STOP;
    strobe(WR);
    trig(4, 1);
    clock_source_select = 2'h1;
    trig(4, 1);
    wrap_limit = 16'h000F;
    trig(32, 2);
    init_trigger_enable = 1'h0;
    trig(16, 0);
    test_done;
  end
endmodule // tb_top
`default_nettype wire
